// ===== inc/cold_boot_cfg.svh
// Constants of the cold-boot loader and its stream sender
`ifndef COLD_BOOT_CFG_SVH
`define COLD_BOOT_CFG_SVH
`define CFG_CORE_CLK_HZ 50000000
`define CFG_ASYNC_BPS 2400
`define CFG_ASYNC_BIT_CYCLES (`CFG_CORE_CLK_HZ / `CFG_ASYNC_BPS)
`define CFG_SYNC_HALF 4'h6
`define CFG_PAR_HOLD 5'h08
`define CFG_MODE_SETTLE 4'h8
`define CFG_FRAME_BITS 4'ha
`define CFG_DATA_BITS 4'h8
`define CFG_IO_BIT 15
`define CFG_END_IO_ADDR 15'h0020
`define CFG_MAP_IO_ADDR 15'h0014
`define CFG_ZERO_BANK_RST 1'h0
`endif

// ===== inc/cold_boot_pkg.sv
// Types shared by both ends of the cold-boot link
`default_nettype none
package cold_boot_pkg;
   typedef enum logic [1:0] {mode_direct, mode_slave, mode_sync, mode_async} boot_mode_t;
   typedef enum logic [1:0] {st_sample, st_boot, st_run} boot_state_t;
endpackage
`default_nettype wire

// ===== inc/cold_boot_link.sv
// Pins between the booting device and the stream sender
`default_nettype none
interface cold_boot_link;
   logic boot_mode_pin0;
   logic boot_mode_pin1;
   logic serial_a_data;
   logic serial_a_clk;
   logic [7:0] slave_data;
   logic slave_wr_n;
   modport dev (input boot_mode_pin0, input boot_mode_pin1, input serial_a_data, input serial_a_clk,
                input slave_data, input slave_wr_n);
   modport host (output boot_mode_pin0, output boot_mode_pin1, output serial_a_data, output serial_a_clk,
                 output slave_data, output slave_wr_n);
endinterface
`default_nettype wire

// ===== hdl/cold_boot_device.sv
// Cold-boot loader of the processor: mode pins, three download channels, triplet writer
`include "cold_boot_cfg.svh"
`default_nettype none
module cold_boot_device
   import cold_boot_pkg::*;
#(
   parameter int BIT_CYCLES = `CFG_ASYNC_BIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   cold_boot_link.dev link,
   input wire logic cpu_rd,
   output logic exec_start,
   output logic booting,
   output logic running,
   output logic mem_wr_en,
   output logic io_wr_en,
   output logic [14:0] wr_addr,
   output logic [7:0] wr_data,
   output logic memory_select0_n,
   output logic memory_output_enable0_n,
   output logic memory_select1_n,
   output logic memory_output_enable1_n
);
   localparam int NSYNC = 5;
   localparam int P_M0 = 0;
   localparam int P_M1 = 1;
   localparam int P_RXD = 2;
   localparam int P_WR = 3;
   localparam int P_TOG = 4;
   localparam logic [NSYNC-1:0] SYNC_INIT = 5'h0c;

   // Link-domain receiver state
   logic lrst1_q, lrst2_q;
   logic lbusy_q;
   logic [3:0] lcnt_q;
   logic [7:0] lsh_q, lbyte_q;
   logic ltog_q;

   // Core-domain state
   logic [NSYNC-1:0] pin_raw, s1_q, s2_q, s3_q, filt_q;
   boot_state_t state_q;
   boot_mode_t mode_q;
   logic [3:0] settle_q;
   logic rxd_prev_q, wr_prev_q, tog_prev_q;
   logic arx_busy_q;
   logic [15:0] arx_timer_q;
   logic [3:0] arx_bit_q;
   logic [7:0] arx_sh_q, arx_byte_q;
   logic arx_ev_q;
   logic byte_ev;
   logic [7:0] byte_val;
   logic [1:0] idx_q;
   logic [7:0] addr_hi_q, addr_lo_q;
   logic [14:0] wr_addr_q;
   logic [7:0] wr_data_q;
   logic mem_wr_q, io_wr_q, exec_q;
   logic zero_bank_q;
   logic [15:0] full_addr;

   // Link reset: asserted at once, released on the link clock, since that clock may not run during reset
   always_ff @(posedge link.serial_a_clk or posedge reset) begin
      if (reset) begin
         lrst1_q <= 1'b1;
         lrst2_q <= 1'b1;
      end else begin
         lrst1_q <= 1'b0;
         lrst2_q <= lrst1_q;
      end
   end

   // Synchronous serial A: framed characters shifted in on the sender's clock
   always_ff @(posedge link.serial_a_clk or posedge lrst2_q) begin
      if (lrst2_q) begin
         lbusy_q <= 1'b0;
         lcnt_q <= 4'h0;
         lsh_q <= 8'h00;
         lbyte_q <= 8'h00;
         ltog_q <= 1'b0;
      end else if (!lbusy_q) begin
         if (!link.serial_a_data) begin
            lbusy_q <= 1'b1;
            lcnt_q <= 4'h0;
         end
      end else if (lcnt_q == `CFG_DATA_BITS) begin
         lbusy_q <= 1'b0;
         if (link.serial_a_data) begin // Bad stop bit drops the character
            lbyte_q <= lsh_q;
            ltog_q <= ~ltog_q;
         end
      end else begin
         lsh_q <= {link.serial_a_data, lsh_q[7:1]};
         lcnt_q <= lcnt_q + 4'h1;
      end
   end

   assign pin_raw = {ltog_q, link.slave_wr_n, link.serial_a_data, link.boot_mode_pin1, link.boot_mode_pin0};

   // Three-stage synchronisers; a level is accepted only when stages two and three agree
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s1_q <= SYNC_INIT;
         s2_q <= SYNC_INIT;
         s3_q <= SYNC_INIT;
         filt_q <= SYNC_INIT;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < NSYNC; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               filt_q[i] <= s3_q[i];
            end
         end
      end
   end

   // Edge history of the filtered pins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rxd_prev_q <= 1'b1;
         wr_prev_q <= 1'b1;
         tog_prev_q <= 1'b0;
      end else begin
         rxd_prev_q <= filt_q[P_RXD];
         wr_prev_q <= filt_q[P_WR];
         tog_prev_q <= filt_q[P_TOG];
      end
   end

   // Asynchronous serial A receiver, sampling each bit at its middle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         arx_busy_q <= 1'b0;
         arx_timer_q <= 16'h0000;
         arx_bit_q <= 4'h0;
         arx_sh_q <= 8'h00;
         arx_byte_q <= 8'h00;
         arx_ev_q <= 1'b0;
      end else begin
         arx_ev_q <= 1'b0;
         if (!arx_busy_q) begin
            if (rxd_prev_q && !filt_q[P_RXD]) begin
               arx_busy_q <= 1'b1;
               arx_timer_q <= 16'(BIT_CYCLES / 2);
               arx_bit_q <= 4'h0;
            end
         end else if (arx_timer_q != 16'h0000) begin
            arx_timer_q <= arx_timer_q - 16'h0001;
         end else begin
            arx_timer_q <= 16'(BIT_CYCLES - 1);
            arx_bit_q <= arx_bit_q + 4'h1;
            if (arx_bit_q == 4'h0) begin
               arx_busy_q <= !filt_q[P_RXD]; // Glitch shorter than half a bit is no start
            end else if (arx_bit_q == `CFG_FRAME_BITS - 4'h1) begin
               arx_busy_q <= 1'b0;
               if (filt_q[P_RXD]) begin
                  arx_byte_q <= arx_sh_q;
                  arx_ev_q <= 1'b1;
               end
            end else begin
               arx_sh_q <= {filt_q[P_RXD], arx_sh_q[7:1]};
            end
         end
      end
   end

   // Byte from the channel that the mode selects; the others are ignored
   // The sync byte word is read straight across: it stands at least ten link clocks after its toggle
   always_comb begin
      byte_ev = 1'b0;
      byte_val = 8'h00;
      unique case (mode_q)
         mode_async: begin
            byte_ev = arx_ev_q;
            byte_val = arx_byte_q;
         end
         mode_sync: begin
            byte_ev = filt_q[P_TOG] != tog_prev_q;
            byte_val = lbyte_q;
         end
         mode_slave: begin
            byte_ev = wr_prev_q && !filt_q[P_WR];
            byte_val = link.slave_data;
         end
         mode_direct: begin
            byte_ev = 1'b0;
            byte_val = 8'h00;
         end
      endcase
   end

   // Startup sequencing: wait for the mode pins to settle, then pick the path
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= st_sample;
         mode_q <= mode_direct;
         settle_q <= 4'h0;
         exec_q <= 1'b0;
      end else begin
         exec_q <= 1'b0;
         unique case (state_q)
            st_sample: begin
               settle_q <= settle_q + 4'h1;
               if (settle_q == `CFG_MODE_SETTLE) begin
                  mode_q <= boot_mode_t'({filt_q[P_M1], filt_q[P_M0]});
                  if (!filt_q[P_M1] && !filt_q[P_M0]) begin
                     state_q <= st_run;
                     exec_q <= 1'b1;
                  end else begin
                     state_q <= st_boot;
                  end
               end
            end
            st_boot: begin
               if (byte_ev && idx_q == 2'h2 && full_addr[`CFG_IO_BIT] &&
                   full_addr[14:0] == `CFG_END_IO_ADDR) begin
                  state_q <= st_run;
                  exec_q <= 1'b1;
               end
            end
            st_run: begin
               state_q <= st_run;
            end
         endcase
      end
   end

   assign full_addr = {addr_hi_q, addr_lo_q};

   // Triplet assembly and the write that each completed triplet makes
   always_ff @(posedge core_clk) begin
      if (reset) begin
         idx_q <= 2'h0;
         addr_hi_q <= 8'h00;
         addr_lo_q <= 8'h00;
         wr_addr_q <= 15'h0000;
         wr_data_q <= 8'h00;
         mem_wr_q <= 1'b0;
         io_wr_q <= 1'b0;
      end else begin
         mem_wr_q <= 1'b0;
         io_wr_q <= 1'b0;
         if (state_q == st_boot && byte_ev) begin
            unique case (idx_q)
               2'h0: begin
                  addr_hi_q <= byte_val;
                  idx_q <= 2'h1;
               end
               2'h1: begin
                  addr_lo_q <= byte_val;
                  idx_q <= 2'h2;
               end
               default: begin
                  idx_q <= 2'h0;
                  wr_addr_q <= full_addr[14:0];
                  wr_data_q <= byte_val;
                  io_wr_q <= full_addr[`CFG_IO_BIT];
                  mem_wr_q <= !full_addr[`CFG_IO_BIT];
               end
            endcase
         end
      end
   end

   // Bank at address zero; a boot-time I/O store can put RAM there before execution
   always_ff @(posedge core_clk) begin
      if (reset) begin
         zero_bank_q <= `CFG_ZERO_BANK_RST;
      end else if (io_wr_q && wr_addr_q == `CFG_MAP_IO_ADDR) begin
         zero_bank_q <= wr_data_q[0];
      end
   end

   // Memory strobes for fetches from the zero region once running
   assign memory_select0_n = !(running && cpu_rd && !zero_bank_q);
   assign memory_output_enable0_n = !(running && cpu_rd && !zero_bank_q);
   assign memory_select1_n = !(running && cpu_rd && zero_bank_q);
   assign memory_output_enable1_n = !(running && cpu_rd && zero_bank_q);

   assign exec_start = exec_q;
   assign booting = state_q == st_boot;
   assign running = state_q == st_run;
   assign mem_wr_en = mem_wr_q;
   assign io_wr_en = io_wr_q;
   assign wr_addr = wr_addr_q;
   assign wr_data = wr_data_q;
endmodule
`default_nettype wire

// ===== hdl/cold_boot_host.sv
// Stream sender that drives the mode pins and sends boot triplets over the chosen channel
`include "cold_boot_cfg.svh"
`default_nettype none
module cold_boot_host
   import cold_boot_pkg::*;
#(
   parameter int BIT_CYCLES = `CFG_ASYNC_BIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   cold_boot_link.host link,
   input wire logic [1:0] boot_mode,
   input wire logic send_valid,
   output logic send_ready,
   input wire logic [15:0] send_addr,
   input wire logic [7:0] send_data
);
   logic [1:0] mode_q;
   logic [3:0] div_q;
   logic sclk_q;
   logic sync_tick, async_tick, tick;
   logic [15:0] atimer_q;
   logic [23:0] tri_q;
   logic [1:0] left_q;
   logic [9:0] frame_q;
   logic [3:0] bits_q;
   logic txd_q;
   logic [4:0] pcnt_q;
   logic [7:0] pdata_q;
   logic wr_n_q;
   logic chan_idle, load;

   // Mode pins follow the request; the device reads them shortly after reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mode_q <= 2'h0;
      end else begin
         mode_q <= boot_mode;
      end
   end

   // Serial clock by division of the core clock; held low during reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         div_q <= 4'h0;
         sclk_q <= 1'b0;
      end else if (div_q == `CFG_SYNC_HALF - 4'h1) begin
         div_q <= 4'h0;
         sclk_q <= ~sclk_q;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   assign sync_tick = sclk_q && div_q == `CFG_SYNC_HALF - 4'h1;

   // Free-running bit timer at the asynchronous rate
   always_ff @(posedge core_clk) begin
      if (reset || atimer_q == 16'h0000) begin
         atimer_q <= 16'(BIT_CYCLES - 1);
      end else begin
         atimer_q <= atimer_q - 16'h0001;
      end
   end

   assign async_tick = atimer_q == 16'h0000;
   assign tick = (mode_q == 2'(mode_async)) ? async_tick : sync_tick;
   assign chan_idle = (mode_q == 2'(mode_slave)) ? (pcnt_q == 5'h00) : (bits_q == 4'h0);
   assign load = left_q != 2'h0 && chan_idle;
   assign send_ready = left_q == 2'h0 && chan_idle;

   // Triplet holding register, sent high address byte first
   always_ff @(posedge core_clk) begin
      if (reset) begin
         tri_q <= 24'h000000;
         left_q <= 2'h0;
      end else if (send_valid && send_ready) begin
         tri_q <= {send_addr, send_data};
         left_q <= (mode_q == 2'(mode_direct)) ? 2'h0 : 2'h3;
      end else if (load) begin
         tri_q <= {tri_q[15:0], 8'h00};
         left_q <= left_q - 2'h1;
      end
   end

   // Serial framing: start bit, eight bits LSB first, stop bit; changes on the falling serial edge in sync mode, on the bit timer in async mode
   always_ff @(posedge core_clk) begin
      if (reset) begin
         frame_q <= 10'h3ff;
         bits_q <= 4'h0;
         txd_q <= 1'b1;
      end else if (load && mode_q != 2'(mode_slave)) begin
         frame_q <= {1'b1, tri_q[23:16], 1'b0};
         bits_q <= `CFG_FRAME_BITS;
      end else if (bits_q != 4'h0 && tick) begin
         txd_q <= frame_q[0];
         frame_q <= {1'b1, frame_q[9:1]};
         bits_q <= bits_q - 4'h1;
      end
   end

   // Slave port: data set up, strobe low for a hold time, then a gap with data still held
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pcnt_q <= 5'h00;
         pdata_q <= 8'h00;
         wr_n_q <= 1'b1;
      end else begin
         wr_n_q <= !(pcnt_q > `CFG_PAR_HOLD && pcnt_q < 5'({`CFG_PAR_HOLD, 1'b0}));
         if (load && mode_q == 2'(mode_slave)) begin
            pdata_q <= tri_q[23:16];
            pcnt_q <= 5'({`CFG_PAR_HOLD, 1'b0});
         end else if (pcnt_q != 5'h00) begin
            pcnt_q <= pcnt_q - 5'h01;
         end
      end
   end

   assign link.boot_mode_pin0 = mode_q[0];
   assign link.boot_mode_pin1 = mode_q[1];
   assign link.serial_a_data = txd_q;
   assign link.serial_a_clk = sclk_q;
   assign link.slave_data = pdata_q;
   assign link.slave_wr_n = wr_n_q;
endmodule
`default_nettype wire

// ===== verif/cold_boot_loader_props.sv
// Concurrent checks on the boot link pins and on the device's run and write outputs
`include "cold_boot_cfg.svh"
`default_nettype none
module cold_boot_loader_props (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic boot_mode_pin0,
   input wire logic boot_mode_pin1,
   input wire logic serial_a_data,
   input wire logic serial_a_clk,
   input wire logic [7:0] slave_data,
   input wire logic slave_wr_n,
   input wire logic cpu_rd,
   input wire logic exec_start,
   input wire logic booting,
   input wire logic running,
   input wire logic mem_wr_en,
   input wire logic io_wr_en,
   input wire logic [14:0] wr_addr,
   input wire logic memory_select0_n,
   input wire logic memory_output_enable0_n,
   input wire logic memory_select1_n,
   input wire logic memory_output_enable1_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Everything here lives in the core clock domain
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   // Pins need time to settle, so no decision in the first cycles after release
   mode_wait_a: assert property ($fell(reset) |-> (!booting && !running) [*8])
      else $error("startup decided too early after reset");
   exec_pulse_a: assert property (exec_start |=> running && !exec_start && !booting)
      else $error("execution start is not a single pulse into run");
   run_holds_a: assert property (running |=> running)
      else $error("run state left without reset");
   mode_excl_a: assert property (!(booting && running))
      else $error("download and run active together");
   one_write_a: assert property ((mem_wr_en || io_wr_en) |-> !(mem_wr_en && io_wr_en) ##1 !(mem_wr_en || io_wr_en))
      else $error("triplet made more than one write");
   end_store_a: assert property ((io_wr_en && wr_addr == `CFG_END_IO_ADDR) |-> exec_start && running)
      else $error("end store did not start execution");
   other_io_a: assert property ((io_wr_en && wr_addr != `CFG_END_IO_ADDR) |-> booting && !exec_start)
      else $error("ordinary io store ended the download");
   mem_write_a: assert property (mem_wr_en |-> booting && !exec_start)
      else $error("memory store outside download");
   // Zero region stays dark until the processor runs
   idle_sel_a: assert property (!running |-> memory_select0_n && memory_select1_n
                                && memory_output_enable0_n && memory_output_enable1_n)
      else $error("memory strobe active before run");
   zero_sel_a: assert property ((running && cpu_rd) |-> memory_select0_n != memory_select1_n
      && memory_output_enable0_n == memory_select0_n && memory_output_enable1_n == memory_select1_n)
      else $error("zero region not served by exactly one bank");
   slave_hold_a: assert property ($fell(slave_wr_n) |=> $stable(slave_data) [*5])
      else $error("slave data moved during write strobe");
   async_start_a: assert property (($fell(serial_a_data) && boot_mode_pin0 && boot_mode_pin1)
                                   |-> !serial_a_data [*8])
      else $error("async start bit too short");
   sync_edge_a: assert property ((boot_mode_pin1 && !boot_mode_pin0 && serial_a_clk && $past(serial_a_clk))
                                 |-> $stable(serial_a_data))
      else $error("sync data changed while bit clock high");
endmodule
`default_nettype wire

// ===== verif/cold_boot_loader_bench.sv
// Self-checking bench: sender and device joined over the link, writes compared with a queue model
`include "cold_boot_cfg.svh"
`default_nettype none
module cold_boot_loader_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // Short bit time keeps async frames cheap; both ends must agree on it
   localparam int BITS = 40;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] boot_mode = 2'h0;
   logic send_valid = 1'b0;
   logic send_ready;
   logic [15:0] send_addr = 16'h0000;
   logic [7:0] send_data = 8'h00;
   logic cpu_rd = 1'b0;
   logic exec_start, booting, running, mem_wr_en, io_wr_en;
   logic [14:0] wr_addr;
   logic [7:0] wr_data;
   logic memory_select0_n, memory_output_enable0_n, memory_select1_n, memory_output_enable1_n;
   int bad_count = 0;
   int check_count = 0;
   int seed = 37944;
   int exec_count = 0;
   logic exp_bank = 1'b0;
   logic [23:0] exp_q[$];

   cold_boot_link link ();
   cold_boot_host #(.BIT_CYCLES(BITS)) cold_boot_host_i (.core_clk(core_clk), .reset(reset), .link(link),
      .boot_mode(boot_mode), .send_valid(send_valid), .send_ready(send_ready), .send_addr(send_addr),
      .send_data(send_data));
   cold_boot_device #(.BIT_CYCLES(BITS)) cold_boot_device_i (.core_clk(core_clk), .reset(reset), .link(link),
      .cpu_rd(cpu_rd), .exec_start(exec_start), .booting(booting), .running(running), .mem_wr_en(mem_wr_en),
      .io_wr_en(io_wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .memory_select0_n(memory_select0_n),
      .memory_output_enable0_n(memory_output_enable0_n), .memory_select1_n(memory_select1_n),
      .memory_output_enable1_n(memory_output_enable1_n));
   cold_boot_loader_props cold_boot_loader_props_i (.core_clk(core_clk), .reset(reset),
      .boot_mode_pin0(link.boot_mode_pin0), .boot_mode_pin1(link.boot_mode_pin1),
      .serial_a_data(link.serial_a_data), .serial_a_clk(link.serial_a_clk), .slave_data(link.slave_data),
      .slave_wr_n(link.slave_wr_n), .cpu_rd(cpu_rd), .exec_start(exec_start), .booting(booting),
      .running(running), .mem_wr_en(mem_wr_en), .io_wr_en(io_wr_en), .wr_addr(wr_addr),
      .memory_select0_n(memory_select0_n), .memory_output_enable0_n(memory_output_enable0_n),
      .memory_select1_n(memory_select1_n), .memory_output_enable1_n(memory_output_enable1_n));

   // 50 MHz core clock
   always #10 core_clk = ~core_clk;

   task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Every write pulse is matched against the oldest triplet still owed
   // Sampled mid-cycle so that the pulses launched at the rising edge have settled
   always @(negedge core_clk) begin
      if (reset === 1'b0 && exec_start === 1'b1) exec_count++;
      if (reset === 1'b0 && (mem_wr_en === 1'b1 || io_wr_en === 1'b1)) begin
         if (exp_q.size() == 0) cmp("unexpected write", 24'h0, 24'h1);
         else cmp("write", exp_q.pop_front(), {io_wr_en, wr_addr, wr_data});
      end
   end

   // One triplet over the user handshake; request held until ready is seen at an edge
   task automatic send(input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge core_clk);
      send_valid = 1'b1;
      send_addr = a;
      send_data = d;
      @(posedge core_clk);
      while (send_ready !== 1'b1 && n < 20000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 20000) cmp("send ready", 24'h1, 24'h0);
      if (boot_mode != 2'h0) begin
         exp_q.push_back({a[15], a[14:0], d});
         if (a == {1'b1, `CFG_MAP_IO_ADDR}) exp_bank = d[0];
      end
      @(negedge core_clk);
      send_valid = 1'b0;
   endtask

   // Full cold boot in one mode: reset, decision, download and end store except in direct mode, zero bank check
   task automatic run_mode(input logic [1:0] m);
      int n;
      logic [31:0] r;
      @(negedge core_clk);
      reset = 1'b1;
      boot_mode = m;
      cpu_rd = 1'b0;
      repeat (16) @(negedge core_clk);
      reset = 1'b0;
      exp_bank = `CFG_ZERO_BANK_RST;
      exp_q.delete();
      exec_count = 0;
      n = 0;
      while (booting !== 1'b1 && running !== 1'b1 && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      cmp("booting", {23'h0, m != 2'h0}, {23'h0, booting});
      cmp("running", {23'h0, m == 2'h0}, {23'h0, running});
      for (int i = 0; i < 2; i++) begin
         r = $random(seed);
         send({1'b0, r[14:0]}, r[23:16]);
      end
      if (m != 2'h0) begin
         r = $random(seed);
         cpu_rd = 1'b1;
         send({1'b1, `CFG_MAP_IO_ADDR}, r[7:0]);
         send(16'h8041, r[15:8]);
         cmp("select while booting", 24'h3, {22'h0, memory_select0_n, memory_select1_n});
         send({1'b1, `CFG_END_IO_ADDR}, r[23:16]);
      end
      cpu_rd = 1'b1;
      n = 0;
      while (running !== 1'b1 && n < 6000) begin
         @(negedge core_clk);
         n++;
      end
      repeat (4) @(negedge core_clk);
      cmp("running", 24'h1, {23'h0, running});
      cmp("exec pulses", 24'h1, exec_count[23:0]);
      cmp("pending writes", 24'h0, 24'(exp_q.size()));
      cmp("zero bank select", {22'h0, exp_bank, ~exp_bank}, {22'h0, memory_select0_n, memory_select1_n});
   endtask

   // Watchdog sized well above the slowest expected run
   initial begin
      #1500000;
      bad_count++;
      conclude();
   end

   // Every mode code once
   initial begin
      for (int m = 0; m < 4; m++) begin
         run_mode(m[1:0]);
      end
      conclude();
   end
endmodule
`default_nettype wire
